/* design/slc_params.svh */
// Constants for the strap latch configuration block
// Function
// (RULE1) The five base address straps are captured at reset release, any value 0 to 1Fh, and held.
// (RULE2) A pulled-up address strap reads one and a pulled-down one reads zero.
// (RULE3) The four ports answer at base address plus 0, 1, 2 and 3.
// (RULE4) The board keeps the base address at or below 1Ch.
// (RULE5) Incoming management PHY address fields are compared against the per-port addresses.
// (RULE6) Each LED pin is a strap input during loading and its level sets that LED's polarity.
// (RULE7) A low LED strap sets the polarity bit to one and drives the LED active high.
// (RULE8) A high LED strap sets the polarity bit to zero and drives the LED active low.
// (RULE9) The five-bit mode strap is captured at reset release and applies to all four ports.
// (RULE10) A broadcast strap of zero enables address-zero broadcast access, one disables it.
// (RULE11) An LED style strap of zero selects tri-colour, one selects individual LEDs.
// (RULE12) The LED style applies to all eight LED outputs.
// (RULE13) All straps are sampled as reset is released, with no internal pulls.
// (RULE14) Without strap configuration the board picks mode 18h single-port or 19h multi-port.
// (RULE15) Captured values stay constant until the next reset whatever the LED pins do.
// (RULE16) LED pins turn to outputs only after sampling is complete.
`ifndef SLC_PARAMS_SVH
`define SLC_PARAMS_SVH
`define SLC_ADDR_W 5
`define SLC_MODE_W 5
`define SLC_NPORT 4
`define SLC_NLED 8
`define SLC_BCAST_ADDR 5'h00
`define SLC_RST_ADDR 5'h00
`define SLC_RST_MODE 5'h18
`define SLC_RST_POL 8'h00
`define SLC_RST_BCAST 1'b0
`define SLC_RST_STYLE 1'b0
`define SLC_SETTLE_CYC 2'h3
`endif

/* design/slc_pkg.sv */
// Types for the strap latch configuration block
`include "slc_params.svh"
package slc_pkg;
  typedef struct packed {
    logic [`SLC_ADDR_W-1:0] base_addr;
    logic [`SLC_MODE_W-1:0] mode;
    logic bcast_en;
    logic led_individual;
    logic [`SLC_NLED-1:0] led_pol;
  } slc_cfg_t;
  typedef enum logic [1:0] {SLC_IDLE, SLC_SETTLE, SLC_RUN} slc_state_t;
endpackage

/* design/slc_strap_latch.sv */
// Strap capture at reset release, address match and LED pin drive
`timescale 1ns/100ps
`default_nettype none
`include "slc_params.svh"
module slc_strap_latch (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [`SLC_ADDR_W-1:0] MGMT_BASE_ADDR_STRAP,
  input wire logic [`SLC_MODE_W-1:0] MODE_STRAP,
  input wire logic BROADCAST_ACCESS_STRAP,
  input wire logic LED_STYLE_STRAP,
  input wire logic [`SLC_NLED-1:0] LED_PIN_IN,
  input wire logic [`SLC_NLED-1:0] LED_ACTIVE,
  input wire logic [`SLC_ADDR_W-1:0] MDIO_PHY_ADDR,
  output var slc_pkg::slc_cfg_t CFG,
  output logic CFG_VALID,
  output logic [`SLC_NPORT-1:0] PORT_SEL,
  output logic [`SLC_NLED-1:0] LED_PIN_OUT,
  output logic [`SLC_NLED-1:0] LED_PIN_OE
);
  import slc_pkg::*;

  // One capture per reset release; later strap moves are never seen
  // Limitation: straps must hold through the third clock edge after release to be caught

  localparam int SW = 2 * `SLC_ADDR_W + `SLC_MODE_W + 2 + `SLC_NLED;

  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic [SW-1:0] s1_d;
  logic [SW-1:0] s2_d;
  slc_state_t st_q;
  slc_state_t st_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  slc_cfg_t cfg_q;
  slc_cfg_t cfg_d;
  logic [`SLC_NPORT-1:0] sel_q;
  logic [`SLC_NPORT-1:0] sel_d;
  logic [`SLC_NLED-1:0] out_q;
  logic [`SLC_NLED-1:0] out_d;
  logic [`SLC_NLED-1:0] oe_q;
  logic [`SLC_NLED-1:0] oe_d;
  logic [`SLC_ADDR_W-1:0] s_base;
  logic [`SLC_MODE_W-1:0] s_mode;
  logic s_bcast;
  logic s_style;
  logic [`SLC_NLED-1:0] s_led;
  logic [`SLC_ADDR_W-1:0] s_maddr;

  logic valid_q;
  logic valid_d;
  logic settle_done;

  // Base above 1Ch wraps upper ports; board must prevent it [RULE4]
  function automatic logic [`SLC_ADDR_W-1:0] port_addr(input logic [`SLC_ADDR_W-1:0] b,
                                                      input int p);
    port_addr = b + p[`SLC_ADDR_W-1:0];
  endfunction

  // Direct hit per port, or every port through the broadcast address
  function automatic logic [`SLC_NPORT-1:0] port_hits(input logic [`SLC_ADDR_W-1:0] a,
                                                      input slc_cfg_t c);
    logic bcast;
    port_hits = '0;
    bcast = c.bcast_en && (a == `SLC_BCAST_ADDR);
    for (int p = 0; p < `SLC_NPORT; p++)
    begin
      port_hits[p] = (a == port_addr(c.base_addr, p)) || bcast; // [RULE3] [RULE5]
    end
  endfunction

  // Pin level for a logical LED request; polarity one drives high when lit
  function automatic logic [`SLC_NLED-1:0] led_level(input logic [`SLC_NLED-1:0] lit,
                                                     input logic [`SLC_NLED-1:0] pol);
    led_level = ~(lit ^ pol); // [RULE7] [RULE8]
  endfunction

  // Raw strap levels into configuration
  // Inverted senses are the pin encodings, not a convenience
  function automatic slc_cfg_t strap_cfg(input logic [`SLC_ADDR_W-1:0] base,
                                         input logic [`SLC_MODE_W-1:0] mode,
                                         input logic bcast_n,
                                         input logic style,
                                         input logic [`SLC_NLED-1:0] leds);
    strap_cfg.base_addr = base; // [RULE1] [RULE2]
    strap_cfg.mode = mode; // [RULE9]
    strap_cfg.bcast_en = ~bcast_n; // [RULE10]
    strap_cfg.led_individual = style; // [RULE11]
    strap_cfg.led_pol = ~leds; // [RULE6] [RULE7] [RULE8]
  endfunction

  // Pins are asynchronous to the core clock
  always_comb
  begin
    s1_d = {MGMT_BASE_ADDR_STRAP,
            MODE_STRAP,
            BROADCAST_ACCESS_STRAP,
            LED_STYLE_STRAP,
            LED_PIN_IN,
            MDIO_PHY_ADDR};
    s2_d = s1_q;
  end

  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  // Only the second stage feeds logic; the first may still be settling
  assign {s_base,
          s_mode,
          s_bcast,
          s_style,
          s_led,
          s_maddr} = s2_q;

  assign settle_done = (cnt_q == `SLC_SETTLE_CYC);

  // Wait out the synchroniser so the latch sees pin levels from the release
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    cfg_d = cfg_q;
    valid_d = valid_q;
    case (st_q)
      SLC_IDLE:
      begin
        // First edge after release; pin levels are still in the chain
        st_d = SLC_SETTLE;
        cnt_d = '0;
      end
      SLC_SETTLE:
      begin
        cnt_d = cnt_q + 2'h1;
        if (settle_done)
        begin
          // Straps have no internal pulls; value is whatever board holds [RULE13]
          cfg_d = strap_cfg(s_base, s_mode, s_bcast, s_style, s_led);
          valid_d = 1'b1;
          st_d = SLC_RUN;
        end
      end
      SLC_RUN:
      begin
        // Captured values frozen until reset [RULE15]
        st_d = SLC_RUN;
        valid_d = 1'b1;
      end
      default:
      begin
        st_d = SLC_IDLE;
        valid_d = 1'b0;
      end
    endcase
  end

  // Nothing answers and no pin is driven before the capture completes
  always_comb
  begin
    sel_d = '0;
    out_d = '0;
    oe_d = '0;
    if (st_q == SLC_RUN)
    begin
      sel_d = port_hits(s_maddr, cfg_q); // [RULE3] [RULE5]
      // Style is global; polarity applies per pin for all eight [RULE12]
      out_d = led_level(LED_ACTIVE, cfg_q.led_pol); // [RULE7] [RULE8]
      // Driving starts a cycle after capture so it cannot disturb the levels
      oe_d = '1; // [RULE16]
    end
  end

  // State, capture and valid flag
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      st_q <= SLC_IDLE;
      cnt_q <= '0;
      valid_q <= 1'b0;
      cfg_q <= '{base_addr: `SLC_RST_ADDR,
                 mode: `SLC_RST_MODE,
                 bcast_en: `SLC_RST_BCAST,
                 led_individual: `SLC_RST_STYLE,
                 led_pol: `SLC_RST_POL};
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      valid_q <= valid_d;
      cfg_q <= cfg_d;
    end
  end

  // Outputs stay quiet and undriven through reset and the capture window
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sel_q <= '0;
      out_q <= '0;
      oe_q <= '0;
    end
    else
    begin
      sel_q <= sel_d;
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  assign CFG = cfg_q;
  assign CFG_VALID = valid_q;
  assign PORT_SEL = sel_q;
  assign LED_PIN_OUT = out_q;
  assign LED_PIN_OE = oe_q;
endmodule
`default_nettype wire

/* tb/slc_strap_latch_properties.sv */
// Checker for strap capture, address match and LED drive
`timescale 1ns/100ps
`default_nettype none
module slc_strap_latch_properties (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [4:0] MGMT_BASE_ADDR_STRAP,
  input wire logic [4:0] MODE_STRAP,
  input wire logic BROADCAST_ACCESS_STRAP,
  input wire logic LED_STYLE_STRAP,
  input wire logic [7:0] LED_PIN_IN,
  input wire logic [7:0] LED_ACTIVE,
  input wire logic [4:0] MDIO_PHY_ADDR,
  input wire slc_pkg::slc_cfg_t CFG,
  input wire logic CFG_VALID,
  input wire logic [3:0] PORT_SEL,
  input wire logic [7:0] LED_PIN_OUT,
  input wire logic [7:0] LED_PIN_OE
);
  import slc_pkg::*;
  logic [4:0] off;
  logic [3:0] hit;
  // Offset wraps mod 32, as the design does
  assign off = MDIO_PHY_ADDR - CFG.base_addr;
  assign hit = (off < 5'h04 ? 4'h1 << off : 4'h0) | {4{CFG.bcast_en && MDIO_PHY_ADDR == 5'h00}};
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  boot_time_a: assert property ($rose(RESETN) |-> !CFG_VALID [*5] ##1 CFG_VALID)
    else $error("capture time");
  cap_addr_a: assert property ($rose(CFG_VALID) |-> CFG.base_addr == $past(MGMT_BASE_ADDR_STRAP)
    && CFG.mode == $past(MODE_STRAP)) else $error("captured address or mode");
  cap_flag_a: assert property ($rose(CFG_VALID) |-> CFG.led_pol == ~$past(LED_PIN_IN)
    && CFG.bcast_en == !$past(BROADCAST_ACCESS_STRAP) && CFG.led_individual == $past(LED_STYLE_STRAP))
    else $error("captured flags");
  cfg_hold_a: assert property (CFG_VALID && $past(CFG_VALID) |-> $stable(CFG))
    else $error("config moved");
  load_quiet_a: assert property (!CFG_VALID |-> LED_PIN_OE == 8'h00 && PORT_SEL == 4'h0)
    else $error("active while loading");
  run_drive_a: assert property (CFG_VALID |=> LED_PIN_OE == 8'hff)
    else $error("pins not driven");
  led_level_a: assert property ($past(CFG_VALID) |-> LED_PIN_OUT == ~($past(LED_ACTIVE) ^ CFG.led_pol))
    else $error("led level");
  addr_match_a: assert property (CFG_VALID ##0 $stable(MDIO_PHY_ADDR) [*4] |=> PORT_SEL == $past(hit))
    else $error("port select");
  cover property ($rose(CFG_VALID));
  cover property (PORT_SEL == 4'hf);
  cover property (CFG_VALID && LED_PIN_OUT != 8'h00);
endmodule
`default_nettype wire

/* tb/slc_board_model.sv */
// Board side: strap pulls on the shared LED pins
`timescale 1ns/100ps
`default_nettype none
module slc_board_model (
  input wire logic [7:0] pull,
  input wire logic [7:0] oe,
  input wire logic [7:0] drv,
  output logic [7:0] pin
);
  // Only external pulls hold the level until the chip drives
  assign pin = (oe & drv) | (~oe & pull);
endmodule
`default_nettype wire

/* tb/slc_strap_latch_bench.sv */
// Self-checking bench for the strap latch block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; $display("wrong value at %0t: mismatch", $time); end end
module slc_strap_latch_bench;
  import slc_pkg::*;
  typedef struct packed {logic [4:0] b; logic [4:0] m; logic c; logic s; logic [7:0] p;} slc_strap_t;
  slc_strap_t tbl [3] = '{'{5'h1c, 5'h18, 1'b0, 1'b1, 8'ha5}, '{5'h00, 5'h19, 1'b1, 1'b0, 8'h3c},
    '{5'h0b, 5'h0a, 1'b0, 1'b0, 8'h00}};
  slc_strap_t st = '0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] act = 8'h00;
  logic [4:0] addr = 5'h00;
  logic [7:0] pin, pout, poe;
  logic [3:0] sel;
  logic valid;
  slc_cfg_t cfg, exp;
  int fails = 0;
  int samples_checked = 0;
  always #12.5 clk = ~clk;
  slc_strap_latch dut (.CORE_CLK(clk), .RESETN(rst_n), .MGMT_BASE_ADDR_STRAP(st.b), .MODE_STRAP(st.m),
    .BROADCAST_ACCESS_STRAP(st.c), .LED_STYLE_STRAP(st.s), .LED_PIN_IN(pin), .LED_ACTIVE(act),
    .MDIO_PHY_ADDR(addr), .CFG(cfg), .CFG_VALID(valid), .PORT_SEL(sel), .LED_PIN_OUT(pout),
    .LED_PIN_OE(poe));
  slc_board_model board (.pull(st.p), .oe(poe), .drv(pout), .pin(pin));
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #100000;
    fails++;
    final_report();
  end
  initial
  begin
    for (int i = 0; i < 3; i++)
    begin
      st = tbl[i];
      exp = {st.b, st.m, ~st.c, st.s, ~st.p};
      rst_n = 1'b0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      `CHK(poe, 8'h00)
      `CHK(pout, 8'h00)
      `CHK(valid, 1'b0)
      repeat (6) @(negedge clk);
      `CHK(cfg, exp)
      `CHK(valid, 1'b1)
      // Offset 4 wraps to address 0 for the top base
      for (int p = 0; p < 5; p++)
      begin
        addr = st.b + 5'(p);
        repeat (6) @(negedge clk);
        `CHK(sel, (p < 4 ? 4'h1 << p : 4'h0) | {4{!st.c && addr == 5'h00}})
      end
      act = 8'h5a ^ st.p;
      repeat (2) @(negedge clk);
      `CHK(pout, act ^ st.p)
      `CHK(poe, 8'hff)
      st = ~st;
      repeat (8) @(negedge clk);
      `CHK(cfg, exp)
    end
    final_report();
  end
endmodule
bind slc_strap_latch slc_strap_latch_properties props (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
  .MGMT_BASE_ADDR_STRAP(MGMT_BASE_ADDR_STRAP), .MODE_STRAP(MODE_STRAP),
  .BROADCAST_ACCESS_STRAP(BROADCAST_ACCESS_STRAP), .LED_STYLE_STRAP(LED_STYLE_STRAP),
  .LED_PIN_IN(LED_PIN_IN), .LED_ACTIVE(LED_ACTIVE), .MDIO_PHY_ADDR(MDIO_PHY_ADDR),
  .CFG(CFG), .CFG_VALID(CFG_VALID), .PORT_SEL(PORT_SEL), .LED_PIN_OUT(LED_PIN_OUT),
  .LED_PIN_OE(LED_PIN_OE));
`default_nettype wire
